// ==== verilog/its_translation_and_features.sv ====
/* Translation front end: takes translation writes tagged with the
   writer's device identifier, checks them, looks them up and forwards
   the interrupt; serves the read-only feature register.
   Assumes the register port, command port and enable share clk_in, and
   that the interconnect attaches an unforgeable device identifier. */
`timescale 1ns/1ps
`default_nettype none
`include "its_defines.svh"
module its_translation_and_features #(
	parameter int SRC_BITS        = 16,
	parameter int DEV_BITS        = 4,
	parameter int EVT_BITS        = 4,
	parameter int COLL_BITS       = 3,
	parameter int COLL_EVENT_ID_WIDTH    = 16,
	parameter int TGT_BITS        = 16,
	parameter int ENTRY_BYTES     = 8,
	parameter bit EXCESS_DISCARD  = 1'b1,
	parameter bit REV31           = 1'b0,
	parameter bit PART_SUPPORT    = 1'b0,
	parameter bit VMOVE_SINGLE    = 1'b0,
	parameter bit WIDE_CIL        = 1'b0,
	parameter bit PHYS_TARGET     = 1'b0,
	parameter bit ERR_SUPPORT     = 1'b0,
	parameter bit MEM_COLLECTIONS = 1'b0,
	parameter bit CUMULATIVE      = 1'b0,
	parameter bit VERSION4        = 1'b0,
	parameter bit VIRT_SUPPORT    = 1'b0
) (
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rstn_in,
	// Register port
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic [15:0]            reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic [3:0]             reg_strb_in,
	input  wire logic [SRC_BITS-1:0]    src_dev_in,
	output logic      [31:0]            reg_rdata_out,
	output logic                        reg_rvalid_out,
	// Service control
	input  wire logic                   enable_in,
	// Table maintenance
	input  wire logic                   cmd_valid_in,
	input  wire its_pkg::cmd_op_t       cmd_op_in,
	input  wire logic [DEV_BITS-1:0]    cmd_dev_in,
	input  wire logic [EVT_BITS-1:0]    cmd_evt_in,
	input  wire logic [COLL_BITS-1:0]   cmd_coll_in,
	input  wire logic [TGT_BITS-1:0]    cmd_arg_in,
	input  wire logic                   cmd_set_in,
	// Translated interrupt and drop report
	output logic                        irq_valid_out,
	output logic [EVT_BITS-1:0]         irq_event_out,
	output logic [COLL_BITS-1:0]        irq_coll_out,
	output logic [TGT_BITS-1:0]         irq_target_out,
	output logic                        irq_phys_addr_out,
	output logic                        drop_valid_out,
	output its_pkg::drop_reason_t       drop_reason_out
);
	import its_pkg::*;

	// Build options the tables and feature word cannot serve
	if (DEV_BITS < 1 || DEV_BITS > 8 || SRC_BITS <= DEV_BITS || SRC_BITS > 32)
		$error("device identifier widths out of range");
	if (EVT_BITS < 1 || EVT_BITS > 12 || COLL_BITS < 1 || COLL_BITS > 7)
		$error("event or collection width out of range");
	if (TGT_BITS < 5 || ENTRY_BYTES < 1 || ENTRY_BYTES > 16)
		$error("target width or entry size out of range");
	if (COLL_EVENT_ID_WIDTH < 1 || COLL_EVENT_ID_WIDTH > `WIDE_COLL_ID)
		$error("collection identifier width out of range");

	table_port_if #(
		.DEV_BITS  (DEV_BITS),
		.EVT_BITS  (EVT_BITS),
		.COLL_BITS (COLL_BITS),
		.TGT_BITS  (TGT_BITS)
	) tp ();

	translation_tables #(
		.DEV_BITS  (DEV_BITS),
		.EVT_BITS  (EVT_BITS),
		.COLL_BITS (COLL_BITS),
		.TGT_BITS  (TGT_BITS)
	) u_tables (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.tp      (tp.tables)
	);

	logic [63:0] feature;

	feature_word #(
		.DEV_BITS        (DEV_BITS),
		.EVT_BITS        (EVT_BITS),
		.COLL_BITS       (COLL_BITS),
		.COLL_EVENT_ID_WIDTH    (COLL_EVENT_ID_WIDTH),
		.REV31           (REV31),
		.PART_SUPPORT    (PART_SUPPORT),
		.VMOVE_SINGLE    (VMOVE_SINGLE),
		.WIDE_CIL        (WIDE_CIL),
		.PHYS_TARGET     (PHYS_TARGET),
		.ERR_SUPPORT     (ERR_SUPPORT),
		.ENTRY_BYTES     (ENTRY_BYTES),
		.MEM_COLLECTIONS (MEM_COLLECTIONS),
		.CUMULATIVE      (CUMULATIVE),
		.VERSION4        (VERSION4),
		.VIRT_SUPPORT    (VIRT_SUPPORT)
	) u_feature (
		.word_out (feature)
	);

	// Maintenance commands pass straight to the tables
	assign tp.cmd_valid = cmd_valid_in;
	assign tp.cmd_op    = cmd_op_in;
	assign tp.cmd_dev   = cmd_dev_in;
	assign tp.cmd_evt   = cmd_evt_in;
	assign tp.cmd_coll  = cmd_coll_in;
	assign tp.cmd_arg   = cmd_arg_in;
	assign tp.cmd_set   = cmd_set_in;

	// Write decode: any non-empty strobe at the translation offset
	logic        tr_write;
	logic [31:0] wr_value;
	assign tr_write = reg_wr_in && reg_addr_in == `TRANSLATION_OFS && |reg_strb_in;

	// Unstrobed lanes count as zero, so a half write clears the top
	always_comb begin
		wr_value = '0;
		for (int b = 0; b < 4; b++) begin
			if (reg_strb_in[b])
				wr_value[8*b +: 8] = reg_wdata_in[8*b +: 8];
		end
	end

	// Request stage: the write and the identifier that came with it
	logic                req_valid;
	logic [31:0]         req_evt;
	logic [SRC_BITS-1:0] req_src;
	logic                req_enabled;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			req_valid <= 1'b0;
		else
			req_valid <= tr_write;
	end

	// Payload of the request stage
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_evt     <= '0;
			req_src     <= '0;
			req_enabled <= 1'b0;
		end else if (tr_write) begin
			req_evt     <= wr_value;
			req_src     <= src_dev_in;
			req_enabled <= enable_in;
		end
	end

	// Lookup: low device bits index the device table
	assign tp.look_dev = req_src[DEV_BITS-1:0];
	assign tp.look_evt = req_evt[EVT_BITS-1:0];

	// Checks in priority order; first failing one names the drop
	logic         src_too_wide;
	logic         evt_excess;
	logic         evt_out_range;
	logic [5:0]   range_shift;
	drop_reason_t next_reason;

	assign src_too_wide = |req_src[SRC_BITS-1:DEV_BITS];
	assign evt_excess   = |req_evt[31:EVT_BITS];
	assign range_shift  = {1'b0, tp.dev_width} + 6'h01;
	// Range follows the width given to the device when it was mapped
	assign evt_out_range = (32'(tp.look_evt) >> range_shift) != 32'h00000000;

	always_comb begin
		next_reason = DROP_NONE;
		if (!req_enabled)
			next_reason = DROP_DISABLED;
		else if (src_too_wide || !tp.dev_mapped)
			next_reason = DROP_DEVICE;
		else if (EXCESS_DISCARD && evt_excess)
			next_reason = DROP_EXCESS;
		else if (evt_out_range)
			next_reason = DROP_RANGE;
		else if (!tp.evt_mapped)
			next_reason = DROP_EVENT;
		else if (!tp.coll_mapped)
			next_reason = DROP_COLLECTION;
	end

	// Answer stage: exactly one of interrupt or drop per request
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_valid_out  <= 1'b0;
			drop_valid_out <= 1'b0;
		end else begin
			irq_valid_out  <= req_valid && next_reason == DROP_NONE;
			drop_valid_out <= req_valid && next_reason != DROP_NONE;
		end
	end

	// Answer payload holds until the next request is answered
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_event_out   <= '0;
			irq_coll_out    <= '0;
			irq_target_out  <= '0;
			drop_reason_out <= DROP_NONE;
		end else if (req_valid) begin
			irq_event_out   <= tp.look_evt;
			irq_coll_out    <= tp.coll;
			irq_target_out  <= tp.target;
			drop_reason_out <= next_reason;
		end
	end

	// Target format is fixed at build time
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			irq_phys_addr_out <= 1'b0;
		else
			irq_phys_addr_out <= PHYS_TARGET;
	end

	// Reads: feature halves; translation and unmapped read zero
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rvalid_out <= 1'b0;
			reg_rdata_out  <= '0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					`FEATURE_LO_OFS: reg_rdata_out <= feature[31:0];
					`FEATURE_HI_OFS: reg_rdata_out <= feature[63:32];
					default:         reg_rdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	// Checks and coverage
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	chk_write_answered: assert property (
		tr_write |-> ##2 (irq_valid_out || drop_valid_out))
		else $error("translation write got no answer");

	chk_single_answer: assert property (
		!(irq_valid_out && drop_valid_out))
		else $error("interrupt and drop in one cycle");

	chk_disabled_drop: assert property (
		tr_write && !enable_in |-> ##2 drop_valid_out && drop_reason_out == DROP_DISABLED)
		else $error("write while disabled was not dropped");

	chk_half_write_zero: assert property (
		tr_write && reg_strb_in == 4'h3 |=> req_evt[31:16] == 16'h0000)
		else $error("half write kept upper bits");

	chk_excess_dropped: assert property (
		tr_write && enable_in && EXCESS_DISCARD && |wr_value[31:EVT_BITS]
		|-> ##2 !irq_valid_out)
		else $error("write with excess event bits was forwarded");

	chk_event_carried: assert property (
		tr_write ##2 irq_valid_out |-> irq_event_out == $past(wr_value[EVT_BITS-1:0], 2))
		else $error("forwarded event differs from written one");

	chk_top_bits_zero: assert property (
		reg_rd_in && reg_addr_in == `FEATURE_HI_OFS |=> reg_rdata_out[31:7] == 25'h0000000)
		else $error("feature bits 63 to 39 not zero");

	chk_phys_bit_one: assert property (
		reg_rd_in && reg_addr_in == `FEATURE_LO_OFS |=> reg_rdata_out[`F_PHYS])
		else $error("physical support bit not one");

	chk_width_fields: assert property (
		reg_rd_in && reg_addr_in == `FEATURE_LO_OFS
		|=> reg_rdata_out[`F_EVTW_LO +: 5] == 5'(EVT_BITS - 1)
		&& reg_rdata_out[`F_DEVW_LO +: 5] == 5'(DEV_BITS - 1))
		else $error("identifier width fields wrong");

	chk_write_only: assert property (
		reg_rd_in && reg_addr_in == `TRANSLATION_OFS |=> reg_rvalid_out && reg_rdata_out == 0)
		else $error("translation register read returned data");

	chk_reset_no_irq: assert property (
		$rose(rstn_in) |-> !irq_valid_out [*2])
		else $error("interrupt right after reset");

	cov_forwarded: cover property (tr_write ##2 irq_valid_out);
	cov_drop_disabled: cover property (drop_valid_out && drop_reason_out == DROP_DISABLED);
	cov_half_write: cover property (tr_write && reg_strb_in == 4'h3 ##2 irq_valid_out);
	cov_back_to_back: cover property (tr_write [*2]);

	// Read pulse, fixed fields and drop paths the bench relies on
	chk_read_valid: assert property (
		reg_rd_in |=> reg_rvalid_out)
		else $error("read got no valid pulse");

	chk_entry_size: assert property (
		reg_rd_in && reg_addr_in == `FEATURE_LO_OFS
		|=> reg_rdata_out[`F_ENTRY_LO +: 4] == 4'(ENTRY_BYTES - 1))
		else $error("entry size field wrong");

	chk_target_format: assert property (
		$past(rstn_in) |-> irq_phys_addr_out == PHYS_TARGET)
		else $error("target format flag wrong");

	chk_unmapped_device: assert property (
		req_valid && req_enabled && !tp.dev_mapped |=> drop_valid_out)
		else $error("write from unmapped device was not dropped");

	chk_range_drop: assert property (
		req_valid && req_enabled && !src_too_wide && tp.dev_mapped && !evt_excess
		&& evt_out_range |=> drop_valid_out && drop_reason_out == DROP_RANGE)
		else $error("event beyond mapped width was not dropped");

	cov_drop_range: cover property (drop_valid_out && drop_reason_out == DROP_RANGE);
endmodule : its_translation_and_features
`default_nettype wire

// ==== common/its_defines.svh ====
/* Register offsets, feature-word field positions and timing counts of the
   translation front end. Included by bare name; holds definitions only. */
// How it works
// - The 32-bit translation field written by a requester names the event.
// - Each mapped device carries its own event width, set by map_device_command.
// - Set bits above the implemented event width drop the write (or are ignored).
// - The source device identifier indexes the device table to find its table.
// - Translation register sits at 0x0040 and is write-only; reads return zero.
// - Feature register is 64-bit read-only at 0x0008; bits 63..39 read zero.
// - Bit 38 reports partition support only on revision 3.1 or later.
// - Bit 37 reports the form of the virtual element move command.
// - Bit 36 selects 16-bit collection ids or width-minus-one in bits 35..32.
// - Bits 31..24 count hardware collections; all start unmapped after reset.
// - Bit 19 says whether targets are element numbers or physical addresses.
// - Bit 18 reports local system error interrupt generation.
// - Bits 17..13 hold implemented source device identifier bits minus one.
// - Bits 12..8 hold implemented event bits minus one; writes checked against it.
// - Bits 7..4 hold translation table entry bytes minus one.
// - Bit 2 cumulative collections; zero without hardware or memory collections.
// - Bit 1 reports virtual interrupt support; zero on version 3 builds.
// - Bit 0 always reads one.
// - Writes are dropped when disabled, device bad, event out of range or unmapped.
// - A 16-bit write to the low half takes the upper half as zero.
`ifndef ITS_DEFINES_SVH
`define ITS_DEFINES_SVH
`define TRANSLATION_OFS 16'h0040
`define FEATURE_LO_OFS  16'h0008
`define FEATURE_HI_OFS  16'h000C
`define F_PARTITION     38
`define F_VMOVE_FORM    37
`define F_COLL_LIMIT    36
`define F_CIDW_LO       32
`define F_HW_COLL_LO    24
`define F_PHYS_TARGET   19
`define F_ERR_INT       18
`define F_DEVW_LO       13
`define F_EVTW_LO       8
`define F_ENTRY_LO      4
`define F_CUMULATIVE    2
`define F_VIRT          1
`define F_PHYS          0
`define WIDE_COLL_ID    16
`define ANSWER_CYCLES   2
`endif

// ==== common/its_pkg.sv ====
/* Types shared by the translation front end modules.
   Assumes nothing of its surroundings. */
`default_nettype none
package its_pkg;
	// Table maintenance operations on the command port
	typedef enum logic [1:0] {CMD_MAP_DEVICE, CMD_MAP_EVENT, CMD_MAP_COLLECTION} cmd_op_t;
	// Why a translation write was dropped
	typedef enum logic [2:0] {
		DROP_NONE, DROP_DISABLED, DROP_DEVICE, DROP_EXCESS,
		DROP_RANGE, DROP_EVENT, DROP_COLLECTION
	} drop_reason_t;
endpackage : its_pkg
`default_nettype wire

// ==== common/table_port_if.sv ====
/* Lookup and maintenance path between the front end and its tables.
   Assumes both ends run on the same clock. */
`timescale 1ns/1ps
`default_nettype none
interface table_port_if #(
	parameter int DEV_BITS  = 4,
	parameter int EVT_BITS  = 4,
	parameter int COLL_BITS = 3,
	parameter int TGT_BITS  = 16
);
	logic [DEV_BITS-1:0]  look_dev;
	logic [EVT_BITS-1:0]  look_evt;
	logic                 dev_mapped;
	logic [4:0]           dev_width;
	logic                 evt_mapped;
	logic [COLL_BITS-1:0] coll;
	logic                 coll_mapped;
	logic [TGT_BITS-1:0]  target;
	logic                 cmd_valid;
	its_pkg::cmd_op_t     cmd_op;
	logic [DEV_BITS-1:0]  cmd_dev;
	logic [EVT_BITS-1:0]  cmd_evt;
	logic [COLL_BITS-1:0] cmd_coll;
	logic [TGT_BITS-1:0]  cmd_arg;
	logic                 cmd_set;
	modport front (output look_dev, look_evt, cmd_valid, cmd_op, cmd_dev, cmd_evt,
		cmd_coll, cmd_arg, cmd_set,
		input dev_mapped, dev_width, evt_mapped, coll, coll_mapped, target);
	modport tables (input look_dev, look_evt, cmd_valid, cmd_op, cmd_dev, cmd_evt,
		cmd_coll, cmd_arg, cmd_set,
		output dev_mapped, dev_width, evt_mapped, coll, coll_mapped, target);
endinterface : table_port_if
`default_nettype wire

// ==== verilog/translation_tables.sv ====
/* Device, per-device event and hardware collection tables.
   Assumes commands and lookups arrive on the table port, same clock. */
`timescale 1ns/1ps
`default_nettype none
module translation_tables #(
	parameter int DEV_BITS  = 4,
	parameter int EVT_BITS  = 4,
	parameter int COLL_BITS = 3,
	parameter int TGT_BITS  = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Table port
	table_port_if.tables tp
);
	import its_pkg::*;
	localparam int NDEV  = 1 << DEV_BITS;
	localparam int NEVT  = 1 << (DEV_BITS + EVT_BITS);
	localparam int NCOLL = 1 << COLL_BITS;
	logic [4:0]                   dev_width_mem [NDEV];
	logic [COLL_BITS-1:0]         evt_coll_mem  [NEVT];
	logic [TGT_BITS-1:0]          coll_tgt_mem  [NCOLL];
	logic [NDEV-1:0]              dev_ok;
	logic [NEVT-1:0]              evt_ok;
	logic [NCOLL-1:0]             coll_ok;
	logic [DEV_BITS+EVT_BITS-1:0] cmd_idx;
	logic [DEV_BITS+EVT_BITS-1:0] look_idx;
	assign cmd_idx  = {tp.cmd_dev, tp.cmd_evt};
	assign look_idx = {tp.look_dev, tp.look_evt};
	// Valid bits only are reset; everything starts unmapped
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dev_ok  <= '0;
			evt_ok  <= '0;
			coll_ok <= '0;
		end else if (tp.cmd_valid) begin
			unique case (tp.cmd_op)
				CMD_MAP_DEVICE:     dev_ok[tp.cmd_dev]   <= tp.cmd_set;
				CMD_MAP_EVENT:      evt_ok[cmd_idx]      <= tp.cmd_set;
				CMD_MAP_COLLECTION: coll_ok[tp.cmd_coll] <= tp.cmd_set;
				default: ;
			endcase
		end
	end
	// Payload arrays need no reset; valid bits guard them
	always_ff @(posedge clk_in) begin
		if (tp.cmd_valid && tp.cmd_op == CMD_MAP_DEVICE)
			dev_width_mem[tp.cmd_dev] <= tp.cmd_arg[4:0];
		if (tp.cmd_valid && tp.cmd_op == CMD_MAP_EVENT)
			evt_coll_mem[cmd_idx] <= tp.cmd_coll;
		if (tp.cmd_valid && tp.cmd_op == CMD_MAP_COLLECTION)
			coll_tgt_mem[tp.cmd_coll] <= tp.cmd_arg;
	end
	// Lookup chain: device, then its event table, then collection
	assign tp.dev_mapped  = dev_ok[tp.look_dev];
	assign tp.dev_width   = dev_width_mem[tp.look_dev];
	assign tp.evt_mapped  = evt_ok[look_idx];
	assign tp.coll        = evt_coll_mem[look_idx];
	assign tp.coll_mapped = coll_ok[tp.coll];
	assign tp.target      = coll_tgt_mem[tp.coll];
endmodule : translation_tables
`default_nettype wire

// ==== verilog/feature_word.sv ====
/* Builds the 64-bit feature word from build options.
   Assumes the options are legal; the top checks them. */
`timescale 1ns/1ps
`default_nettype none
`include "its_defines.svh"
module feature_word #(
	parameter int DEV_BITS = 4, EVT_BITS = 4, COLL_BITS = 3, COLL_EVENT_ID_WIDTH = 16,
	parameter bit REV31 = 1'b0, PART_SUPPORT = 1'b0, VMOVE_SINGLE = 1'b0,
	parameter bit WIDE_CIL = 1'b0, PHYS_TARGET = 1'b0, ERR_SUPPORT = 1'b0,
	parameter int ENTRY_BYTES = 8,
	parameter bit MEM_COLLECTIONS = 1'b0, CUMULATIVE = 1'b0,
	parameter bit VERSION4 = 1'b0, VIRT_SUPPORT = 1'b0
) (
	// Feature word
	output logic [63:0] word_out
);
	// Fields packed into place; unlisted bits stay zero
	always_comb begin
		word_out = '0;
		word_out[`F_PARTITION]  = REV31 & PART_SUPPORT;
		word_out[`F_VMOVE_FORM] = VMOVE_SINGLE;
		word_out[`F_COLL_LIMIT] = WIDE_CIL & MEM_COLLECTIONS;
		if (WIDE_CIL && MEM_COLLECTIONS)
			word_out[`F_CIDW_LO +: 4] = 4'(COLL_EVENT_ID_WIDTH - 1);
		word_out[`F_HW_COLL_LO +: 8] = 8'((1 << COLL_BITS) & 8'hFF);
		word_out[`F_PHYS_TARGET]     = PHYS_TARGET;
		word_out[`F_ERR_INT]         = ERR_SUPPORT;
		word_out[`F_DEVW_LO +: 5]  = 5'(DEV_BITS - 1);
		word_out[`F_EVTW_LO +: 5]  = 5'(EVT_BITS - 1);
		word_out[`F_ENTRY_LO +: 4] = 4'(ENTRY_BYTES - 1);
		word_out[`F_CUMULATIVE] = CUMULATIVE & MEM_COLLECTIONS & (COLL_BITS < 8);
		word_out[`F_VIRT] = VERSION4 & VIRT_SUPPORT;
		word_out[`F_PHYS] = 1'b1;
	end
endmodule : feature_word
`default_nettype wire

// ==== tb/requester_model.sv ====
/* Model of the requesting devices that post translation writes over the
   interconnect, each tagged with its own device identifier.
   Assumes the bench calls send and muxes the address while wr_out is high. */
`timescale 1ns/1ps
`default_nettype none
module requester_model (
	// Clock
	input  wire logic   clk_in,
	// Write request side of the register port
	output logic        wr_out,
	output logic [15:0] addr_out,
	output logic [31:0] data_out,
	output logic [3:0]  strb_out,
	output logic [15:0] src_out
);
	bit chained;

	// Idle at time zero: no request pending
	initial begin
		wr_out = 1'b0;
		addr_out = 16'h0000;
		data_out = 32'h00000000;
		strb_out = 4'h0;
		src_out = 16'h0000;
		chained = 1'b0;
	end

	// One write, held until the edge that takes it; keep chains the next one
	task automatic send(input logic [15:0] addr, input logic [31:0] data,
		input logic [3:0] strb, input logic [15:0] src, input bit keep);
		if (!chained) begin
			@(posedge clk_in);
		end
		wr_out <= 1'b1;
		addr_out <= addr;
		data_out <= data;     // Whole event field
		strb_out <= strb;     // Low lanes only for a 16-bit write
		src_out <= src;       // Interconnect tag, never taken from data
		@(posedge clk_in);
		chained = keep;
		// Released lines show garbage so stale values cannot pass
		if (!keep) begin
			wr_out <= 1'b0;
			addr_out <= ~addr;
			data_out <= ~data;
			strb_out <= ~strb;
			src_out <= ~src;
		end
	endtask : send
endmodule : requester_model
`default_nettype wire

// ==== tb/its_translation_and_features_test.sv ====
/* Self-checking bench of the translation front end: feature word, lookups,
   drop reasons, 16-bit writes and reset. Assumes the requester model drives
   the write side and the bench drives reads, commands and enable. */
`timescale 1ns/1ps
`default_nettype none
`include "its_defines.svh"
module its_translation_and_features_test;
	import its_pkg::*;
	localparam bit PT = 1'b1;
	localparam bit ES = 1'b1;
	// Low word: 8 hardware collections, 4-bit ids, 8-byte entries, physical bit
	localparam logic [31:0] FEAT_LO = (32'h08 << 24) | (32'(PT) << 19) | (32'(ES) << 18)
		| (32'h3 << 13) | (32'h3 << 8) | (32'h7 << 4) | 32'h1;
	// Bench-driven inputs
	logic          clk_in;
	logic          rstn_in;
	logic          rd_en;
	logic [15:0]   rd_addr;
	logic          en;
	logic          cv;
	logic [29:0]   cmdv;
	// Requester and design outputs
	wire           p_wr;
	wire  [15:0]   p_addr;
	wire  [31:0]   p_data;
	wire  [3:0]    p_strb;
	wire  [15:0]   p_src;
	wire  [15:0]   reg_addr;
	logic [31:0]   rdata;
	logic          rvalid;
	logic          irq_v;
	logic [3:0]    irq_evt;
	logic [2:0]    irq_coll;
	logic [15:0]   irq_tgt;
	logic          phys;
	logic          drop_v;
	drop_reason_t  why;
	int            error_cnt;
	int            checks_done;

	// Writes own the address only while p_wr is up
	assign reg_addr = p_wr ? p_addr : rd_addr;

	requester_model req (.clk_in(clk_in), .wr_out(p_wr), .addr_out(p_addr),
		.data_out(p_data), .strb_out(p_strb), .src_out(p_src));

	its_translation_and_features #(.PHYS_TARGET(PT), .ERR_SUPPORT(ES)) dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .reg_wr_in(p_wr), .reg_rd_in(rd_en),
		.reg_addr_in(reg_addr), .reg_wdata_in(p_data), .reg_strb_in(p_strb),
		.src_dev_in(p_src), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.enable_in(en), .cmd_valid_in(cv), .cmd_op_in(cmd_op_t'(cmdv[29:28])),
		.cmd_dev_in(cmdv[27:24]), .cmd_evt_in(cmdv[23:20]), .cmd_coll_in(cmdv[19:17]),
		.cmd_arg_in(cmdv[16:1]), .cmd_set_in(cmdv[0]), .irq_valid_out(irq_v),
		.irq_event_out(irq_evt), .irq_coll_out(irq_coll), .irq_target_out(irq_tgt),
		.irq_phys_addr_out(phys), .drop_valid_out(drop_v), .drop_reason_out(why));

	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : cmp_word

	task automatic cmp_bit(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask : cmp_bit

	task automatic print_verdict;
		$display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	// Read: answer stands for one cycle right after the taking edge
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk_in);
		rd_en <= 1'b0;
		#1;
		cmp_bit("reg_rvalid", 1'b1, rvalid);
		cmp_word("reg_rdata", exp, rdata);
	endtask : rd

	task automatic cmd(input cmd_op_t o, input logic [3:0] d, input logic [3:0] e,
		input logic [2:0] c, input logic [15:0] a, input logic s);
		@(posedge clk_in);
		cmdv <= {o, d, e, c, a, s};
		cv <= 1'b1;
		@(posedge clk_in);
		cv <= 1'b0;
	endtask : cmd

	// Translation write; returns at the edge that shows its answer
	task automatic tw(input logic [31:0] d, input logic [3:0] s, input logic [15:0] src);
		req.send(`TRANSLATION_OFS, d, s, src, 1'b0);
		@(posedge clk_in);
	endtask : tw

	// Exactly one of the two pulses, looked at while it stands; then one edge on
	task automatic expect_ans(input bit irq, input logic [3:0] evt, input logic [2:0] coll,
		input logic [15:0] tgt, input drop_reason_t r);
		#1;
		cmp_bit("irq_valid", irq, irq_v);
		cmp_bit("drop_valid", !irq, drop_v);
		if (irq) begin
			cmp_word("irq_event", {28'h0, evt}, {28'h0, irq_evt});
			cmp_word("irq_coll", {29'h0, coll}, {29'h0, irq_coll});
			cmp_word("irq_target", {16'h0, tgt}, {16'h0, irq_tgt});
			cmp_bit("irq_phys_addr", PT, phys);
		end else begin
			cmp_word("drop_reason", {29'h0, r}, {29'h0, why});
		end
		@(posedge clk_in);
	endtask : expect_ans

	// Reset held 16 cycles; target format shows at the first edge after release
	task automatic reset_dut;
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (16) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		#1;
		cmp_bit("irq_phys_addr", PT, phys);
	endtask : reset_dut

	task automatic t_features;
		rd(`FEATURE_LO_OFS, FEAT_LO);
		rd(`FEATURE_HI_OFS, 32'h0);
		rd(`TRANSLATION_OFS, 32'h0);
		req.send(`FEATURE_LO_OFS, 32'hFFFFFFFF, 4'hF, 16'h0000, 1'b0);
		rd(`FEATURE_LO_OFS, FEAT_LO);
	endtask : t_features

	// Collections start unmapped; two devices reach different tables
	task automatic t_translate;
		cmd(CMD_MAP_DEVICE, 4'h2, 4'h0, 3'h0, 16'h0003, 1'b1);
		cmd(CMD_MAP_EVENT, 4'h2, 4'h1, 3'h4, 16'h0000, 1'b1);
		tw(32'h1, 4'hF, 16'h0002);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_COLLECTION);
		cmd(CMD_MAP_COLLECTION, 4'h0, 4'h0, 3'h4, 16'h0123, 1'b1);
		cmd(CMD_MAP_DEVICE, 4'h3, 4'h0, 3'h0, 16'h0003, 1'b1);
		cmd(CMD_MAP_COLLECTION, 4'h0, 4'h0, 3'h2, 16'h0055, 1'b1);
		cmd(CMD_MAP_EVENT, 4'h3, 4'h1, 3'h2, 16'h0000, 1'b1);
		tw(32'h1, 4'hF, 16'h0002);
		expect_ans(1'b1, 4'h1, 3'h4, 16'h0123, DROP_NONE);
		tw(32'h1, 4'hF, 16'h0003);
		expect_ans(1'b1, 4'h1, 3'h2, 16'h0055, DROP_NONE);
	endtask : t_translate

	task automatic t_drops;
		@(posedge clk_in);
		en <= 1'b0;
		tw(32'h1, 4'hF, 16'h0002);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_DISABLED);
		@(posedge clk_in);
		en <= 1'b1;
		tw(32'h1, 4'hF, 16'h0012);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_DEVICE);
		tw(32'h1, 4'hF, 16'h0009);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_DEVICE);
		tw(32'h11, 4'hF, 16'h0002);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_EXCESS);
		tw(32'h5, 4'hF, 16'h0002);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_EVENT);
		cmd(CMD_MAP_DEVICE, 4'h6, 4'h0, 3'h0, 16'h0001, 1'b1);
		tw(32'h4, 4'hF, 16'h0006);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_RANGE);
		tw(32'h3, 4'hF, 16'h0006);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_EVENT);
		cmd(CMD_MAP_EVENT, 4'h3, 4'h1, 3'h2, 16'h0000, 1'b0);
		tw(32'h1, 4'hF, 16'h0003);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_EVENT);
	endtask : t_drops

	// Back to back: a 16-bit write with junk above, then a full write with bit 16 set
	task automatic t_half;
		req.send(`TRANSLATION_OFS, 32'hFFFF0001, 4'h3, 16'h0002, 1'b1);
		req.send(`TRANSLATION_OFS, 32'h00010001, 4'hF, 16'h0002, 1'b0);
		expect_ans(1'b1, 4'h1, 3'h4, 16'h0123, DROP_NONE);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_EXCESS);
	endtask : t_half

	// Mid-run reset must forget the mapping of device 2
	task automatic t_reset;
		reset_dut();
		tw(32'h1, 4'hF, 16'h0002);
		expect_ans(1'b0, 4'h0, 3'h0, 16'h0, DROP_DEVICE);
	endtask : t_reset

	// Main sequence
	initial begin
		rstn_in = 1'b0;
		rd_en = 1'b0;
		rd_addr = 16'h0000;
		en = 1'b1;
		cv = 1'b0;
		cmdv = 30'h0;
		error_cnt = 0;
		checks_done = 0;
		reset_dut();
		t_features();
		t_translate();
		t_drops();
		t_half();
		t_reset();
		print_verdict();
	end

	// Watchdog well beyond the roughly 120 cycles the run needs
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
endmodule : its_translation_and_features_test
`default_nettype wire
